// ### core/t1as_pkg.sv
/*
  Shared constants and carrier types for the receive-side alarm and
  status block of one framer: register indices, bit positions, reset
  values, detector thresholds and timing.
  Assumes a 10 MHz system clock and 32-bit APB register access.
*/
package t1as_pkg;
  // register indices (byte address is four times the index)
  localparam logic [15:0] REG_IDX_LATCHED_1 = 16'h0090;
  localparam logic [15:0] REG_IDX_MASK_1 = 16'h00A0;
  localparam logic [15:0] REG_IDX_REALTIME_1 = 16'h00B0;
  localparam logic [15:0] REG_IDX_LINE_CTRL_2 = 16'h0014;
  localparam logic [15:0] REG_IDX_FRAMING = 16'h0015;
  localparam logic [15:0] FRAMER_STRIDE = 16'h0200;

  // real-time status bit positions
  localparam int RT_FRAME_LOSS = 0;
  localparam int RT_CARRIER_LOSS = 1;
  localparam int RT_BLUE = 2;
  localparam int RT_YELLOW = 3;
  // latched status bit positions
  localparam int LB_FRAME_LOSS = 0;
  localparam int LB_CARRIER_LOSS = 1;
  localparam int LB_BLUE = 2;
  localparam int LB_YELLOW = 3;
  localparam int LB_FRAME_REGAIN = 4;
  localparam int LB_CARRIER_BACK = 5;
  localparam int LB_BLUE_END = 6;
  localparam int LB_YELLOW_END = 7;
  // control bit positions
  localparam int LC2_YELLOW_FBIT_MODE = 0;
  localparam int FR_T1_MODE = 0;
  localparam int FR_ESF = 1;

  // reset values
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
  localparam logic [7:0] FRAMING_RESET = 8'h01;

  // detector thresholds
  localparam logic [2:0] BLUE_MAX_ZEROS = 3'h4;
  localparam logic [8:0] BIT2_WINDOW = 9'h100;
  localparam logic [8:0] BIT2_MIN_ZEROS = 9'h0FE;
  localparam logic [4:0] FDL_RUN = 5'h10;
  localparam logic [15:0] FDL_PATTERN = 16'h00FF;
  localparam logic [4:0] FDL_CLEAR_MATCHES = 5'h0E;
  localparam logic [7:0] LOS_ZEROS = 8'hC0;
  localparam logic [6:0] LOS_WINDOW = 7'h70;
  localparam logic [3:0] LOS_MIN_ONES = 4'hE;

  // timing
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int BLUE_WINDOW_NS = 3000000;
  localparam int BLUE_WINDOW_CYCLES = BLUE_WINDOW_NS / CLOCK_PERIOD_NS;

  // present state of the four alarm conditions
  typedef struct packed {
    logic yellow;
    logic blue;
    logic carrier_loss;
    logic frame_loss;
  } t1as_alarm_type;

  // one received line bit with its strobe
  typedef struct packed {
    logic valid;
    logic value;
  } t1as_bit_type;
endpackage

// ### core/t1as_alarm_status.sv
/*
  Receive alarm detection and status reporting for one T1 framer:
  blue, yellow and carrier-loss detectors, real-time and latched status,
  interrupt masking and an APB register slave.
  Assumes all framer inputs are synchronous strobes on clock and that
  the framer reports its own loss of frame synchronisation.
*/
// How it works
// [RQ1] latched bit holds until host clears it
// [RQ2] writing one clears latched bit, zero keeps
// [RQ3] cleared bit sets again only on fresh event
// [RQ4] real-time bits read-only, reads change nothing
// [RQ5] real-time value stable during host read
// [RQ6] unmasked latched event drives interrupt low
// [RQ7] interrupt returns high when nothing unmasked pends
// [RQ8] clearing works even while alarm persists
// [RQ9] real-time bit 0 high while out of frame
// [RQ10] latched bit 0 sets on frame-loss rise
// [RQ11] latched bit 4 sets on frame-loss fall
// [RQ12] blue alarm by zeros per 3 ms window
// [RQ13] D4 bit-2 yellow: 254 of 256 zero
// [RQ14] D4 12th F-bit yellow: two consecutive
// [RQ15] ESF yellow: sixteen 00FF patterns in link
// [RQ16] carrier loss after 192 consecutive zeros
// [RQ17] carrier back: 14 ones in 112 bits
// [RQ18] host qualifies blue alarm with frame loss
// [RQ19] framer n registers at offset (n-1)*200h
// [RQ20] only latched bits drive the interrupt
// [RQ21] detectors follow framing format and T1 mode
module t1as_alarm_status #(
  parameter int FRAMER_NUM = 1,
  parameter int BLUE_WINDOW_CYCLES = t1as_pkg::BLUE_WINDOW_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame_loss,
  input wire t1as_pkg::t1as_bit_type rx_line_bit,
  input wire t1as_pkg::t1as_bit_type rx_chan_bit2,
  input wire t1as_pkg::t1as_bit_type rx_fbit12,
  input wire logic rx_fdl_valid,
  input wire logic [15:0] rx_fdl_word,
  output logic interrupt_request_n
);
  localparam logic [15:0] FRAMER_BASE = 16'((FRAMER_NUM - 1) * t1as_pkg::FRAMER_STRIDE);

  // framer n sits one stride per framer above framer one [RQ19]
  function automatic logic [15:0] byte_addr(input logic [15:0] idx);
    logic [15:0] sum;
    sum = idx + FRAMER_BASE;
    byte_addr = {sum[13:0], 2'b00};
  endfunction

  localparam logic [15:0] A_LATCHED = byte_addr(t1as_pkg::REG_IDX_LATCHED_1);
  localparam logic [15:0] A_MASK = byte_addr(t1as_pkg::REG_IDX_MASK_1);
  localparam logic [15:0] A_REALTIME = byte_addr(t1as_pkg::REG_IDX_REALTIME_1);
  localparam logic [15:0] A_LINE_CTRL = byte_addr(t1as_pkg::REG_IDX_LINE_CTRL_2);
  localparam logic [15:0] A_FRAMING = byte_addr(t1as_pkg::REG_IDX_FRAMING);

  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_n_reg;
  logic [7:0] latched_reg;
  logic [7:0] mask_reg;
  logic [7:0] line_ctrl_reg;
  logic [7:0] framing_reg;
  t1as_pkg::t1as_alarm_type rt_reg;
  t1as_pkg::t1as_alarm_type rt_prev_reg;
  logic blue_reg;
  logic yellow_reg;
  logic los_reg;
  logic [15:0] blue_win_reg;
  logic [2:0] blue_zeros_reg;
  logic [8:0] b2_cnt_reg;
  logic [8:0] b2_zeros_reg;
  logic [1:0] fbit_hist_reg;
  logic [4:0] fdl_run_reg;
  logic [4:0] fdl_cnt_reg;
  logic [4:0] fdl_match_reg;
  logic [7:0] los_zeros_reg;
  logic los_win_open_reg;
  logic [6:0] los_win_reg;
  logic [3:0] los_ones_reg;

  logic t1_mode;
  logic esf;
  logic setup;
  logic access_done;
  logic wr_done;
  logic addr_ok;
  logic [7:0] set_events;
  logic [7:0] clear_bits;
  logic [7:0] latched_next;
  logic [7:0] mask_next;

  assign t1_mode = framing_reg[t1as_pkg::FR_T1_MODE];
  assign esf = framing_reg[t1as_pkg::FR_ESF];
  assign setup = psel & ~penable;
  // mask as it will stand after this edge, so a new mask takes effect at once
  assign mask_next = (wr_done && paddr == A_MASK) ? pwdata[7:0] : mask_reg;
  assign access_done = psel & penable & pready_reg;
  assign wr_done = access_done & pwrite & ~pslverr_reg;
  assign addr_ok = (paddr == A_LATCHED) | (paddr == A_MASK) | (paddr == A_REALTIME) |
                   (paddr == A_LINE_CTRL) | (paddr == A_FRAMING);

  // apb: no wait states; read data captured in setup, so it cannot move
  // during the access even if an alarm changes meanwhile [RQ5]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= ~addr_ok;
        case (paddr)
          A_LATCHED: prdata_reg <= {24'h000000, latched_reg};
          A_MASK: prdata_reg <= {24'h000000, mask_reg};
          A_REALTIME: prdata_reg <= {28'h0000000, rt_reg};
          A_LINE_CTRL: prdata_reg <= {24'h000000, line_ctrl_reg};
          A_FRAMING: prdata_reg <= {24'h000000, framing_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end else if (access_done) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // control registers; the real-time register has no write path [RQ4]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= t1as_pkg::MASK_RESET;
      line_ctrl_reg <= t1as_pkg::LINE_CTRL_RESET;
      framing_reg <= t1as_pkg::FRAMING_RESET;
    end else if (wr_done) begin
      if (paddr == A_MASK) mask_reg <= pwdata[7:0];
      if (paddr == A_LINE_CTRL) line_ctrl_reg <= pwdata[7:0];
      if (paddr == A_FRAMING) framing_reg <= pwdata[7:0];
    end
  end

  // real-time status; everything idles outside T1 mode [RQ21]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rt_reg <= '0;
      rt_prev_reg <= '0;
    end else begin
      rt_reg.frame_loss <= rx_frame_loss & t1_mode; // [RQ9]
      rt_reg.carrier_loss <= los_reg;
      rt_reg.blue <= blue_reg;
      rt_reg.yellow <= yellow_reg;
      rt_prev_reg <= rt_reg;
    end
  end

  // blue alarm: count zeros over a fixed window, decide at its end [RQ12]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      blue_win_reg <= 16'h0000;
      blue_zeros_reg <= 3'h0;
      blue_reg <= 1'b0;
    end else if (!t1_mode) begin
      blue_win_reg <= 16'h0000;
      blue_zeros_reg <= 3'h0;
      blue_reg <= 1'b0;
    end else if (blue_win_reg == 16'(BLUE_WINDOW_CYCLES - 1)) begin
      blue_win_reg <= 16'h0000;
      blue_zeros_reg <= 3'h0;
      // a zero on the closing cycle still belongs to this window
      blue_reg <= (blue_zeros_reg + 3'(rx_line_bit.valid & ~rx_line_bit.value)) <=
                  t1as_pkg::BLUE_MAX_ZEROS; // [RQ12]
    end else begin
      blue_win_reg <= blue_win_reg + 16'h0001;
      // saturate at five: anything above four clears the alarm anyway
      if (rx_line_bit.valid && !rx_line_bit.value &&
          blue_zeros_reg <= t1as_pkg::BLUE_MAX_ZEROS) begin
        blue_zeros_reg <= blue_zeros_reg + 3'h1;
      end
    end
  end

  // yellow alarm; only the criterion of the chosen format applies [RQ21]
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      yellow_reg <= 1'b0;
      b2_cnt_reg <= 9'h000;
      b2_zeros_reg <= 9'h000;
      fbit_hist_reg <= 2'h0;
      fdl_run_reg <= 5'h00;
      fdl_cnt_reg <= 5'h00;
      fdl_match_reg <= 5'h00;
    end else if (!t1_mode) begin
      yellow_reg <= 1'b0;
      b2_cnt_reg <= 9'h000;
      b2_zeros_reg <= 9'h000;
      fbit_hist_reg <= 2'h0;
      fdl_run_reg <= 5'h00;
      fdl_cnt_reg <= 5'h00;
      fdl_match_reg <= 5'h00;
    end else if (esf) begin
      // run of matches sets; a 16-pattern window with <=14 matches clears
      if (rx_fdl_valid) begin
        if (rx_fdl_word == t1as_pkg::FDL_PATTERN) begin
          if (fdl_run_reg == t1as_pkg::FDL_RUN - 5'h01) yellow_reg <= 1'b1; // [RQ15]
          if (fdl_run_reg != t1as_pkg::FDL_RUN) fdl_run_reg <= fdl_run_reg + 5'h01;
        end else begin
          fdl_run_reg <= 5'h00;
        end
        if (fdl_cnt_reg == t1as_pkg::FDL_RUN - 5'h01) begin
          fdl_cnt_reg <= 5'h00;
          fdl_match_reg <= 5'h00;
          if (fdl_match_reg + 5'(rx_fdl_word == t1as_pkg::FDL_PATTERN) <=
              t1as_pkg::FDL_CLEAR_MATCHES) begin
            yellow_reg <= 1'b0; // [RQ15]
          end
        end else begin
          fdl_cnt_reg <= fdl_cnt_reg + 5'h01;
          fdl_match_reg <= fdl_match_reg + 5'(rx_fdl_word == t1as_pkg::FDL_PATTERN);
        end
      end
    end else if (line_ctrl_reg[t1as_pkg::LC2_YELLOW_FBIT_MODE]) begin
      // two equal 12th F-bits in a row decide the state [RQ14]
      if (rx_fbit12.valid) begin
        fbit_hist_reg <= {fbit_hist_reg[0], rx_fbit12.value};
        if (fbit_hist_reg[0] && rx_fbit12.value) yellow_reg <= 1'b1;
        if (!fbit_hist_reg[0] && !rx_fbit12.value) yellow_reg <= 1'b0;
      end
    end else if (rx_chan_bit2.valid) begin
      // bit 2 of 256 channels, judged once per block of channels [RQ13]
      if (b2_cnt_reg == t1as_pkg::BIT2_WINDOW - 9'h001) begin
        b2_cnt_reg <= 9'h000;
        b2_zeros_reg <= 9'h000;
        yellow_reg <= (b2_zeros_reg + 9'(!rx_chan_bit2.value)) >=
                      t1as_pkg::BIT2_MIN_ZEROS;
      end else begin
        b2_cnt_reg <= b2_cnt_reg + 9'h001;
        b2_zeros_reg <= b2_zeros_reg + 9'(!rx_chan_bit2.value);
      end
    end
  end

  // carrier loss: a zero run sets it; a window opened by a one clears it
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      los_reg <= 1'b0;
      los_zeros_reg <= 8'h00;
      los_win_open_reg <= 1'b0;
      los_win_reg <= 7'h00;
      los_ones_reg <= 4'h0;
    end else if (!t1_mode) begin
      los_reg <= 1'b0;
      los_zeros_reg <= 8'h00;
      los_win_open_reg <= 1'b0;
      los_win_reg <= 7'h00;
      los_ones_reg <= 4'h0;
    end else if (rx_line_bit.valid) begin
      if (rx_line_bit.value) begin
        los_zeros_reg <= 8'h00;
      end else if (los_zeros_reg != t1as_pkg::LOS_ZEROS) begin
        los_zeros_reg <= los_zeros_reg + 8'h01;
      end
      if (!los_reg) begin
        los_win_open_reg <= 1'b0;
        if (!rx_line_bit.value && los_zeros_reg == t1as_pkg::LOS_ZEROS - 8'h01) begin
          los_reg <= 1'b1; // [RQ16]
        end
      end else if (!los_win_open_reg) begin
        // first one opens the window and counts as its first bit
        if (rx_line_bit.value) begin
          los_win_open_reg <= 1'b1;
          los_win_reg <= 7'h01;
          los_ones_reg <= 4'h1;
        end
      end else begin
        if (rx_line_bit.value && los_ones_reg != t1as_pkg::LOS_MIN_ONES) begin
          los_ones_reg <= los_ones_reg + 4'h1;
        end
        if (los_win_reg == t1as_pkg::LOS_WINDOW - 7'h01) begin
          los_win_open_reg <= 1'b0;
          // too few ones: wait for the next one and try again [RQ17]
          if (los_ones_reg + 4'(rx_line_bit.value) >= t1as_pkg::LOS_MIN_ONES) begin
            los_reg <= 1'b0;
          end
        end else begin
          los_win_reg <= los_win_reg + 7'h01;
        end
      end
    end
  end

  // edge events on the real-time bits; a steady alarm yields no event [RQ3]
  always_comb begin
    set_events = 8'h00;
    set_events[t1as_pkg::LB_FRAME_LOSS] = rt_reg.frame_loss & ~rt_prev_reg.frame_loss; // [RQ10]
    set_events[t1as_pkg::LB_FRAME_REGAIN] = ~rt_reg.frame_loss & rt_prev_reg.frame_loss; // [RQ11]
    set_events[t1as_pkg::LB_CARRIER_LOSS] = rt_reg.carrier_loss & ~rt_prev_reg.carrier_loss;
    set_events[t1as_pkg::LB_CARRIER_BACK] = ~rt_reg.carrier_loss & rt_prev_reg.carrier_loss;
    set_events[t1as_pkg::LB_BLUE] = rt_reg.blue & ~rt_prev_reg.blue;
    set_events[t1as_pkg::LB_BLUE_END] = ~rt_reg.blue & rt_prev_reg.blue;
    set_events[t1as_pkg::LB_YELLOW] = rt_reg.yellow & ~rt_prev_reg.yellow;
    set_events[t1as_pkg::LB_YELLOW_END] = ~rt_reg.yellow & rt_prev_reg.yellow;
    clear_bits = (wr_done && paddr == A_LATCHED) ? pwdata[7:0] : 8'h00; // [RQ2]
    // hold, write-one-to-clear regardless of the alarm, set beats clear
    latched_next = (latched_reg & ~clear_bits) | set_events; // [RQ1] [RQ8]
  end

  // latched status
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      latched_reg <= 8'h00;
    end else begin
      latched_reg <= latched_next;
    end
  end

  // interrupt from masked latched bits only, never from real-time bits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~|(latched_next & mask_next); // [RQ6] [RQ7] [RQ20]
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign interrupt_request_n = irq_n_reg;

  a_latch_hold: assert property (@(posedge clock) disable iff (!reset_n) // [RQ1]
    latched_reg[2] && !(wr_done && paddr == A_LATCHED && pwdata[2]) |=> latched_reg[2])
    else $error("latched blue bit dropped without a clear");

  a_write_clear: assert property (@(posedge clock) disable iff (!reset_n) // [RQ2]
    wr_done && paddr == A_LATCHED && pwdata[0] && !set_events[0] |=> !latched_reg[0])
    else $error("write of one did not clear latched bit");

  a_no_resample: assert property (@(posedge clock) disable iff (!reset_n) // [RQ3]
    !latched_reg[0] && rt_reg.frame_loss && rt_prev_reg.frame_loss |=> !latched_reg[0])
    else $error("latched bit set by persisting condition");

  a_read_stable: assert property (@(posedge clock) disable iff (!reset_n) // [RQ5]
    setup && paddr == A_REALTIME |=> pready && prdata[3:0] == $past(rt_reg) &&
    prdata[31:4] == 28'h0000000)
    else $error("real-time read data not held from setup");

  a_frame_loss_rt: assert property (@(posedge clock) disable iff (!reset_n) // [RQ9]
    t1_mode && rx_frame_loss |=> rt_reg.frame_loss)
    else $error("real-time frame loss not shown");

  a_loss_rise: assert property (@(posedge clock) disable iff (!reset_n) // [RQ10]
    $rose(rt_reg.frame_loss) |=> latched_reg[0])
    else $error("frame loss edge not latched");

  a_regain_fall: assert property (@(posedge clock) disable iff (!reset_n) // [RQ11]
    $fell(rt_reg.frame_loss) |=> latched_reg[4])
    else $error("frame regain edge not latched");

  a_irq_assert: assert property (@(posedge clock) disable iff (!reset_n) // [RQ6]
    |(latched_reg & mask_reg) |-> !interrupt_request_n)
    else $error("unmasked event without interrupt");

  a_irq_release: assert property (@(posedge clock) disable iff (!reset_n) // [RQ7]
    !(|(latched_reg & mask_reg)) |-> interrupt_request_n)
    else $error("interrupt low with nothing pending");

  a_los_assert: assert property (@(posedge clock) disable iff (!reset_n) // [RQ16]
    t1_mode && !los_reg && rx_line_bit.valid && !rx_line_bit.value &&
    los_zeros_reg == t1as_pkg::LOS_ZEROS - 8'h01 |=> los_reg ##1 rt_reg.carrier_loss)
    else $error("carrier loss not raised after zero run");
endmodule

// ### tb/t1as_host_model.sv
/*
  Host processor model: the APB master that reads status and clears
  latched bits of the alarm block.
  Assumes one clock; the slave answers with pready, no fixed latency.
*/
module t1as_host_model (
  input wire logic clock,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
  end

  // one transfer; request held until pready is seen, bounded wait
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic late);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // answer is taken at the rising edge that sees pready, then released
    @(posedge clock);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    late = (n >= 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read first, then write ones only where clearing is wanted
  task automatic clear_bits(input logic [15:0] a, input logic [7:0] bits,
                            output logic late);
    logic [31:0] q;
    logic e;
    logic l1;
    xfer(1'b0, a, 32'h00000000, q, e, l1);
    xfer(1'b1, a, {24'h000000, q[7:0] & bits}, q, e, late);
    late = late | l1;
  endtask

  // blue alarm is only trusted by software when frame loss is clear
endmodule

// ### tb/testbench.sv
/*
  Self-checking bench for the receive alarm and status block.
  Assumes the host model drives APB; shortened blue window of 200 clocks.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] A_LAT = t1as_pkg::REG_IDX_LATCHED_1 << 2;
  localparam logic [15:0] A_MSK = t1as_pkg::REG_IDX_MASK_1 << 2;
  localparam logic [15:0] A_RT = t1as_pkg::REG_IDX_REALTIME_1 << 2;
  localparam logic [15:0] A_LC2 = t1as_pkg::REG_IDX_LINE_CTRL_2 << 2;
  localparam logic [15:0] A_FRM = t1as_pkg::REG_IDX_FRAMING << 2;

  logic clock;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_frame_loss;
  t1as_pkg::t1as_bit_type rx_line_bit;
  t1as_pkg::t1as_bit_type rx_chan_bit2;
  t1as_pkg::t1as_bit_type rx_fbit12;
  logic rx_fdl_valid;
  logic [15:0] rx_fdl_word;
  logic interrupt_request_n;
  logic last_err;
  int n_errors;
  int total_checks;

  t1as_alarm_status #(.FRAMER_NUM(1), .BLUE_WINDOW_CYCLES(200)) t1as_alarm_status_i (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_loss(rx_frame_loss), .rx_line_bit(rx_line_bit), .rx_chan_bit2(rx_chan_bit2),
    .rx_fbit12(rx_fbit12), .rx_fdl_valid(rx_fdl_valid), .rx_fdl_word(rx_fdl_word),
    .interrupt_request_n(interrupt_request_n));

  t1as_host_model t1as_host_model_i (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic results;
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // a hung bus counts as a mismatch and ends the run
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic late;
    t1as_host_model_i.xfer(w, a, d, q, last_err, late);
    if (late) begin
      n_errors++;
      results();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input string name, input logic [15:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h00000000, q);
    chk(name, exp, q & m);
  endtask

  task automatic clr(input logic [7:0] bits);
    logic late;
    t1as_host_model_i.clear_bits(A_LAT, bits, late);
    if (late) begin
      n_errors++;
      results();
    end
  endtask

  // let the edge's updates land before looking at the level
  task automatic chk_irq(input logic exp);
    @(negedge clock);
    chk("interrupt", {31'h0, exp}, {31'h0, interrupt_request_n});
  endtask

  // n strobes on one input, the first `ones` carry a one (or the pattern)
  task automatic pulse(input int which, input int n, input int ones);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      case (which)
        0: rx_line_bit <= {1'b1, i < ones};
        1: rx_chan_bit2 <= {1'b1, i < ones};
        2: rx_fbit12 <= {1'b1, i < ones};
        default: begin
          rx_fdl_valid <= 1'b1;
          rx_fdl_word <= (i < ones) ? t1as_pkg::FDL_PATTERN : 16'h0000;
        end
      endcase
    end
    @(posedge clock);
    rx_line_bit <= 2'h0;
    rx_chan_bit2 <= 2'h0;
    rx_fbit12 <= 2'h0;
    rx_fdl_valid <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    rd("mask", A_MSK, 32'hFFFFFFFF, 32'h0);
    rd("framing", A_FRM, 32'hFFFFFFFF, 32'h1);
    rd("line_ctrl", A_LC2, 32'hFFFFFFFF, 32'h0);
    rd("latched", A_LAT, 32'hFFFFFFFF, 32'h0);
    wr(A_RT, 32'h000000FF);
    rd("realtime", A_RT, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, 16'h03FC, 32'h0, q);
    chk("unmapped_err", 32'h1, {31'h0, last_err});
    chk("unmapped_data", 32'h0, q);
    chk_irq(1'b1);
  endtask

  task automatic t_frame;
    wr(A_MSK, 32'h000000FF);
    @(posedge clock);
    rx_frame_loss <= 1'b1;
    repeat (3) @(posedge clock);
    rd("rt_frame", A_RT, 32'hFFFFFFFF, 32'h1);
    rd("lat_loss", A_LAT, 32'hFFFFFFFF, 32'h1);
    chk_irq(1'b0);
    wr(A_LAT, 32'h0);
    rd("lat_hold", A_LAT, 32'hFFFFFFFF, 32'h1);
    clr(8'h01);
    chk_irq(1'b1);
    repeat (5) @(posedge clock);
    rd("lat_rearm", A_LAT, 32'hFFFFFFFF, 32'h0);
    rx_frame_loss <= 1'b0;
    repeat (3) @(posedge clock);
    rd("lat_regain", A_LAT, 32'hFFFFFFFF, 32'h10);
    chk_irq(1'b0);
    clr(8'h10);
    chk_irq(1'b1);
  endtask

  task automatic t_line;
    pulse(0, 600, 600);
    rd("blue_on", A_RT, 32'h4, 32'h4);
    repeat (6) pulse(0, 100, 98);
    rd("blue_four", A_RT, 32'h4, 32'h4);
    clr(8'hFF);
    // groups of ten zeros: every window holds a whole group, well over four
    repeat (6) pulse(0, 100, 90);
    rd("blue_off", A_RT, 32'h4, 32'h0);
    rd("blue_end", A_LAT, 32'h40, 32'h40);
    clr(8'hFF);
    pulse(0, 1, 1);
    pulse(0, 191, 0);
    rd("los_191", A_RT, 32'h2, 32'h0);
    pulse(0, 1, 0);
    rd("los_192", A_RT, 32'h2, 32'h2);
    pulse(0, 112, 13);
    rd("los_13", A_RT, 32'h2, 32'h2);
    pulse(0, 112, 14);
    rd("los_14", A_RT, 32'h2, 32'h0);
    rd("lat_los", A_LAT, 32'h22, 32'h22);
  endtask

  task automatic t_yellow;
    pulse(1, 256, 2);
    rd("bit2_254", A_RT, 32'h8, 32'h8);
    pulse(1, 256, 3);
    rd("bit2_253", A_RT, 32'h8, 32'h0);
    wr(A_LC2, 32'h1);
    pulse(2, 1, 1);
    rd("fbit_one", A_RT, 32'h8, 32'h0);
    pulse(2, 1, 1);
    rd("fbit_two", A_RT, 32'h8, 32'h8);
    pulse(2, 1, 0);
    rd("fbit_zero", A_RT, 32'h8, 32'h8);
    pulse(2, 1, 0);
    rd("fbit_clr", A_RT, 32'h8, 32'h0);
    wr(A_FRM, 32'h3);
    pulse(3, 15, 15);
    rd("fdl_15", A_RT, 32'h8, 32'h0);
    pulse(3, 1, 1);
    rd("fdl_16", A_RT, 32'h8, 32'h8);
    pulse(3, 32, 0);
    rd("fdl_clr", A_RT, 32'h8, 32'h0);
    wr(A_FRM, 32'h2);
    pulse(3, 16, 16);
    rd("t1_off", A_RT, 32'h8, 32'h0);
  endtask

  initial begin
    n_errors = 0;
    total_checks = 0;
    last_err = 1'b0;
    reset_n = 1'b0;
    rx_frame_loss = 1'b0;
    rx_line_bit = 2'h0;
    rx_chan_bit2 = 2'h0;
    rx_fbit12 = 2'h0;
    rx_fdl_valid = 1'b0;
    rx_fdl_word = 16'h0000;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_frame();
    t_line();
    t_yellow();
    results();
  end
endmodule
